// file: verilog/idv_pkg.sv
`default_nettype none
package idv_pkg;
  // APB byte offsets
  localparam logic [7:0] OFS_VBASE = 8'h00;
  localparam logic [7:0] OFS_DCR = 8'h04;
  localparam logic [7:0] OFS_STAT_LO = 8'h08;
  localparam logic [7:0] OFS_STAT_HI = 8'h0C;
  localparam logic [7:0] OFS_SAVE_LO = 8'h10;
  localparam logic [7:0] OFS_SAVE_HI = 8'h14;
  localparam logic [7:0] OFS_SAVE_IP = 8'h18;
  localparam logic [7:0] OFS_ISR = 8'h1C;
  localparam logic [7:0] OFS_FETCH = 8'h20;
  localparam logic [7:0] OFS_CORE = 8'h24;
  // Vector table is one 32 KiB region, so the base keeps bits 31:15 only
  localparam int VT_LSB = 15;
  // Default control register bits
  localparam int DCR_BO = 0;
  localparam int DCR_PM = 1;
  // Status word bit positions
  localparam int PSR_BO = 1;
  localparam int PSR_UP = 2;
  localparam int PSR_AC = 3;
  localparam int PSR_MFL = 4;
  localparam int PSR_MFH = 5;
  localparam int COLLECTION_ENABLE = 13;
  localparam int PSR_I = 14;
  localparam int PSR_PK = 15;
  localparam int PSR_DT = 17;
  localparam int PSR_DFL = 18;
  localparam int PSR_DFH = 19;
  localparam int PSR_SP = 20;
  localparam int PSR_PM = 21;
  localparam int PSR_DI = 22;
  localparam int PSR_SI = 23;
  localparam int PSR_DB = 24;
  localparam int PSR_LP = 25;
  localparam int PSR_TB = 26;
  localparam int PSR_RT = 27;
  localparam int PSR_CPL_LO = 32;
  localparam int PSR_CPL_HI = 33;
  localparam int PSR_IS = 34;
  localparam int PSR_MC = 35;
  localparam int INSTR_TRANSLATION_ON = 36;
  localparam int PSR_ID = 37;
  localparam int PSR_DA = 38;
  localparam int PSR_IA = 39;
  localparam int PSR_DD = 40;
  localparam int PSR_RI_LO = 41;
  localparam int PSR_RI_HI = 42;
  localparam int PSR_ED = 43;
  localparam int PSR_SS = 44;
  localparam int BANK_SELECT = 45;
  // Values after reset
  localparam logic [63:0] STAT_RST = 64'h0;
  localparam logic [31:0] WORD_RST = 32'h0;
  localparam logic [1:0] DCR_RST = 2'h0;
endpackage
`default_nettype wire

// file: verilog/idv_delivery.sv
// Operation
// [RQ1] Entry address is vector base plus per-interruption offset.
// [RQ2] Delivery stops at current IP, sets privilege 0, fetches entry.
// [RQ3] Vector table is one 32 KiB region; offsets stay inside it.
// [RQ4] Base is virtual when instruction translation is 1, else physical.
// [RQ5] Delivery clears external-interrupt and collection enables.
// [RQ6] Platform-management interrupt blocked while collection is 0.
// [RQ7] Delivery clears bank select; handler uses bank 0.
// [RQ8] Byte order bit loaded from default byte order.
// [RQ9] Data, stack, instruction translation and key enable kept.
// [RQ10] Both FP disable bits cleared; modified bits kept.
// [RQ11] Privileged monitor bit loaded from default control register.
// [RQ12] User monitor kept; secure monitor, intercept, timer bits cleared.
// [RQ13] Alignment check enable cleared.
// [RQ14] Breakpoint, lower-privilege, taken-branch, single-step cleared.
// [RQ15] Instruction set selector cleared to native set.
// [RQ16] Debug, access, dirty suppression and deferral bits cleared.
// [RQ17] Restart slot cleared so handler starts at slot 0.
// [RQ18] Machine-check mask kept; reset and bus init never masked.
// [RQ19] Frame load enable cleared on delivery.
// [RQ20] Status register records which shared-vector cause occurred.
// [RQ21] Handlers avoid bank-0 GR24-31 while collection is 1.
// [RQ22] With collection on, status word and slot saved.
// [RQ23] Return restores status word and fetches saved pointer.
// [RQ24] Interruption registers captured only when collection is on.
// [RQ25] All delivery updates land together in one edge.
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module idv_delivery (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic deliver_in,
  input wire logic [14:0] vec_offset_in,
  input wire logic [31:0] cur_ip_in,
  input wire logic [1:0] cur_slot_in,
  input wire logic [31:0] cause_info_in,
  input wire logic rfi_in,
  input wire logic pmi_req_in,
  input wire logic mcheck_req_in,
  input wire logic bus_init_in,
  input wire logic reset_evt_in,
  output logic redirect_out,
  output logic [31:0] fetch_addr_out,
  output logic fetch_virtual_out,
  output logic [63:0] status_out,
  output logic frame_load_enable_out,
  output logic pmi_deliver_out,
  output logic abort_out
);
  logic [31:0] vbase_q;
  logic [1:0] dcr_q;
  logic [63:0] status_q;
  logic [63:0] env_d;
  logic [63:0] saved_q;
  logic [63:0] saved_d;
  logic [31:0] saved_ip_q;
  logic [31:0] isr_q;
  logic [31:0] fetch_q;
  logic redirect_q;
  logic virt_q;
  logic cfle_q;
  logic [31:0] rdata_q;
  logic err_q;
  logic wr;
  logic setup;
  logic collect;
  logic do_rfi;
  logic hit;

  assign wr = psel_in & penable_in & pwrite_in;
  assign setup = psel_in & ~penable_in;
  assign collect = status_q[idv_pkg::COLLECTION_ENABLE];
  // Delivery outranks a return arriving in the same cycle
  assign do_rfi = rfi_in & ~deliver_in;

  // Handler environment, built from the pre-delivery status word
  always_comb begin
    env_d = status_q;
    env_d[idv_pkg::PSR_BO] = dcr_q[idv_pkg::DCR_BO]; // [RQ8]
    env_d[idv_pkg::COLLECTION_ENABLE] = 1'b0; // [RQ5]
    env_d[idv_pkg::PSR_I] = 1'b0; // [RQ5]
    env_d[idv_pkg::BANK_SELECT] = 1'b0; // [RQ7]
    env_d[idv_pkg::PSR_DFL] = 1'b0; // [RQ10]
    env_d[idv_pkg::PSR_DFH] = 1'b0; // [RQ10]
    env_d[idv_pkg::PSR_PM] = dcr_q[idv_pkg::DCR_PM]; // [RQ11]
    env_d[idv_pkg::PSR_SP] = 1'b0; // [RQ12]
    env_d[idv_pkg::PSR_DI] = 1'b0; // [RQ12]
    env_d[idv_pkg::PSR_SI] = 1'b0; // [RQ12]
    env_d[idv_pkg::PSR_AC] = 1'b0; // [RQ13]
    env_d[idv_pkg::PSR_DB] = 1'b0; // [RQ14]
    env_d[idv_pkg::PSR_LP] = 1'b0; // [RQ14]
    env_d[idv_pkg::PSR_TB] = 1'b0; // [RQ14]
    env_d[idv_pkg::PSR_SS] = 1'b0; // [RQ14]
    env_d[idv_pkg::PSR_CPL_HI:idv_pkg::PSR_CPL_LO] = 2'h0; // [RQ2]
    env_d[idv_pkg::PSR_IS] = 1'b0; // [RQ15]
    env_d[idv_pkg::PSR_ID] = 1'b0; // [RQ16]
    env_d[idv_pkg::PSR_DA] = 1'b0; // [RQ16]
    env_d[idv_pkg::PSR_IA] = 1'b0; // [RQ16]
    env_d[idv_pkg::PSR_DD] = 1'b0; // [RQ16]
    env_d[idv_pkg::PSR_ED] = 1'b0; // [RQ16]
    env_d[idv_pkg::PSR_RI_HI:idv_pkg::PSR_RI_LO] = 2'h0; // [RQ17]
    // Translation, key enable, modified bits, user monitor and machine-check
    // mask pass through untouched from status_q
  end

  always_comb begin
    saved_d = status_q; // [RQ22]
    saved_d[idv_pkg::PSR_RI_HI:idv_pkg::PSR_RI_LO] = cur_slot_in; // [RQ22]
  end

  // One edge swaps the whole word, so no partial environment is visible
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      status_q <= idv_pkg::STAT_RST;
    end else if (deliver_in) begin
      status_q <= env_d; // [RQ25] [RQ9] [RQ18]
    end else if (do_rfi) begin
      status_q <= saved_q; // [RQ23]
    end else if (wr && paddr_in == idv_pkg::OFS_STAT_LO) begin
      status_q[31:0] <= pwdata_in;
    end else if (wr && paddr_in == idv_pkg::OFS_STAT_HI) begin
      status_q[63:32] <= pwdata_in;
    end
  end

  // Saved copies; hardware capture wins over a software write
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      saved_q <= idv_pkg::STAT_RST;
      saved_ip_q <= idv_pkg::WORD_RST;
      isr_q <= idv_pkg::WORD_RST;
    end else if (deliver_in && collect) begin
      saved_q <= saved_d; // [RQ22] [RQ24]
      saved_ip_q <= cur_ip_in; // [RQ2] [RQ24]
      isr_q <= cause_info_in; // [RQ20] [RQ24]
    end else if (wr && !deliver_in) begin
      if (paddr_in == idv_pkg::OFS_SAVE_LO) begin
        saved_q[31:0] <= pwdata_in;
      end
      if (paddr_in == idv_pkg::OFS_SAVE_HI) begin
        saved_q[63:32] <= pwdata_in;
      end
      if (paddr_in == idv_pkg::OFS_SAVE_IP) begin
        saved_ip_q <= pwdata_in;
      end
    end
  end

  // Fetch redirection
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      fetch_q <= idv_pkg::WORD_RST;
      redirect_q <= 1'b0;
      virt_q <= 1'b0;
    end else if (deliver_in) begin
      fetch_q <= {vbase_q[31:idv_pkg::VT_LSB], vec_offset_in}; // [RQ1] [RQ3]
      redirect_q <= 1'b1; // [RQ2]
      virt_q <= status_q[idv_pkg::INSTR_TRANSLATION_ON]; // [RQ4]
    end else if (do_rfi) begin
      fetch_q <= saved_ip_q; // [RQ23]
      redirect_q <= 1'b1;
      virt_q <= saved_q[idv_pkg::INSTR_TRANSLATION_ON];
    end else begin
      redirect_q <= 1'b0;
    end
  end

  // Control registers owned by software
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      vbase_q <= idv_pkg::WORD_RST;
      dcr_q <= idv_pkg::DCR_RST;
    end else if (wr) begin
      if (paddr_in == idv_pkg::OFS_VBASE) begin
        // Low bits read zero: the table is aligned to its own size
        vbase_q <= {pwdata_in[31:idv_pkg::VT_LSB], 15'h0000}; // [RQ3]
      end
      if (paddr_in == idv_pkg::OFS_DCR) begin
        dcr_q <= pwdata_in[1:0];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cfle_q <= 1'b0;
    end else if (deliver_in) begin
      cfle_q <= 1'b0; // [RQ19]
    end else if (wr && paddr_in == idv_pkg::OFS_CORE) begin
      cfle_q <= pwdata_in[0];
    end
  end

  // Firmware-level events; platform-management gated by collection, machine check by its mask
  assign pmi_deliver_out = pmi_req_in & collect; // [RQ6]
  assign abort_out = reset_evt_in | bus_init_in |
                     (mcheck_req_in & ~status_q[idv_pkg::PSR_MC]); // [RQ18]

  always_comb begin
    hit = 1'b1;
    unique case (paddr_in)
      idv_pkg::OFS_VBASE, idv_pkg::OFS_DCR, idv_pkg::OFS_STAT_LO,
      idv_pkg::OFS_STAT_HI, idv_pkg::OFS_SAVE_LO, idv_pkg::OFS_SAVE_HI,
      idv_pkg::OFS_SAVE_IP, idv_pkg::OFS_ISR, idv_pkg::OFS_FETCH,
      idv_pkg::OFS_CORE: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // Read data is latched in the setup cycle, so access needs no wait
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rdata_q <= idv_pkg::WORD_RST;
      err_q <= 1'b0;
    end else if (setup) begin
      err_q <= ~hit;
      unique case (paddr_in)
        idv_pkg::OFS_VBASE: rdata_q <= vbase_q;
        idv_pkg::OFS_DCR: rdata_q <= {30'h0, dcr_q};
        idv_pkg::OFS_STAT_LO: rdata_q <= status_q[31:0];
        idv_pkg::OFS_STAT_HI: rdata_q <= status_q[63:32];
        idv_pkg::OFS_SAVE_LO: rdata_q <= saved_q[31:0];
        idv_pkg::OFS_SAVE_HI: rdata_q <= saved_q[63:32];
        idv_pkg::OFS_SAVE_IP: rdata_q <= saved_ip_q;
        idv_pkg::OFS_ISR: rdata_q <= isr_q;
        idv_pkg::OFS_FETCH: rdata_q <= fetch_q;
        idv_pkg::OFS_CORE: rdata_q <= {30'h0, virt_q, cfle_q};
        default: rdata_q <= idv_pkg::WORD_RST;
      endcase
    end
  end

  assign prdata_out = rdata_q;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in & penable_in & err_q;
  assign redirect_out = redirect_q;
  assign fetch_addr_out = fetch_q;
  assign fetch_virtual_out = virt_q;
  assign status_out = status_q;
  assign frame_load_enable_out = cfle_q;

  // Delivery and return checks sample the edge after the triggering cycle, when the whole new
  // environment is already visible on the outputs
  a_entry_addr: assert property (@(posedge clk_in) disable iff (reset_in) // [RQ1]
    deliver_in |=> redirect_out && fetch_addr_out ==
      {$past(vbase_q[31:idv_pkg::VT_LSB]), $past(vec_offset_in)})
    else $error("entry address wrong");

  a_base_align: assert property (@(posedge clk_in) disable iff (reset_in) // [RQ3]
    vbase_q[idv_pkg::VT_LSB-1:0] == 15'h0000)
    else $error("vector base not aligned to table size");

  a_priv_zero: assert property (@(posedge clk_in) disable iff (reset_in) // [RQ2]
    deliver_in |=> status_q[idv_pkg::PSR_CPL_HI:idv_pkg::PSR_CPL_LO] == 2'h0
      && saved_ip_q == ($past(collect) ? $past(cur_ip_in) : $past(saved_ip_q)))
    else $error("privilege or saved pointer wrong");

  a_redirect_src: assert property (@(posedge clk_in) disable iff (reset_in) // [RQ2]
    !deliver_in && !do_rfi |=> !redirect_out)
    else $error("redirect without a cause");

  a_virt_flag: assert property (@(posedge clk_in) disable iff (reset_in) // [RQ4]
    deliver_in |=> fetch_virtual_out == $past(status_q[idv_pkg::INSTR_TRANSLATION_ON]))
    else $error("translation mode of base wrong");

  a_enables_off: assert property (@(posedge clk_in) disable iff (reset_in) // [RQ5]
    deliver_in |=> !status_q[idv_pkg::COLLECTION_ENABLE] && !status_q[idv_pkg::PSR_I]
      && !status_q[idv_pkg::BANK_SELECT])
    else $error("enables not cleared");

  a_pmi_block: assert property (@(posedge clk_in) disable iff (reset_in) // [RQ6]
    pmi_deliver_out |-> status_q[idv_pkg::COLLECTION_ENABLE])
    else $error("pmi passed while collection off");

  a_pmi_pass: assert property (@(posedge clk_in) disable iff (reset_in) // [RQ6]
    pmi_req_in && collect |-> pmi_deliver_out)
    else $error("pmi held while collection on");

  a_bank_zero: assert property (@(posedge clk_in) disable iff (reset_in) // [RQ7]
    deliver_in |=> !status_q[idv_pkg::BANK_SELECT])
    else $error("bank select not cleared");

  a_dcr_copy: assert property (@(posedge clk_in) disable iff (reset_in) // [RQ8]
    deliver_in |=> status_q[idv_pkg::PSR_BO] == $past(dcr_q[idv_pkg::DCR_BO])
      && status_q[idv_pkg::PSR_PM] == $past(dcr_q[idv_pkg::DCR_PM]))
    else $error("default bits not loaded");

  a_bits_kept: assert property (@(posedge clk_in) disable iff (reset_in) // [RQ9]
    deliver_in |=> status_q[idv_pkg::INSTR_TRANSLATION_ON] == $past(status_q[idv_pkg::INSTR_TRANSLATION_ON])
      && status_q[idv_pkg::PSR_DT] == $past(status_q[idv_pkg::PSR_DT])
      && status_q[idv_pkg::PSR_MC] == $past(status_q[idv_pkg::PSR_MC]))
    else $error("kept bits changed");

  a_keys_kept: assert property (@(posedge clk_in) disable iff (reset_in) // [RQ9]
    deliver_in |=> status_q[idv_pkg::PSR_PK] == $past(status_q[idv_pkg::PSR_PK])
      && status_q[idv_pkg::PSR_RT] == $past(status_q[idv_pkg::PSR_RT]))
    else $error("key or stack translation changed");

  a_fp_open: assert property (@(posedge clk_in) disable iff (reset_in) // [RQ10]
    deliver_in |=> !status_q[idv_pkg::PSR_DFL] && !status_q[idv_pkg::PSR_DFH]
      && status_q[idv_pkg::PSR_MFL] == $past(status_q[idv_pkg::PSR_MFL])
      && status_q[idv_pkg::PSR_MFH] == $past(status_q[idv_pkg::PSR_MFH]))
    else $error("floating-point bits wrong");

  a_pm_copy: assert property (@(posedge clk_in) disable iff (reset_in) // [RQ11]
    deliver_in |=> status_q[idv_pkg::PSR_PM] == $past(dcr_q[idv_pkg::DCR_PM]))
    else $error("privileged monitor not loaded");

  a_monitor_bits: assert property (@(posedge clk_in) disable iff (reset_in) // [RQ12]
    deliver_in |=> status_q[idv_pkg::PSR_UP] == $past(status_q[idv_pkg::PSR_UP])
      && !status_q[idv_pkg::PSR_SP] && !status_q[idv_pkg::PSR_DI]
      && !status_q[idv_pkg::PSR_SI])
    else $error("monitor or timer bits wrong");

  a_align_off: assert property (@(posedge clk_in) disable iff (reset_in) // [RQ13]
    deliver_in |=> !status_q[idv_pkg::PSR_AC])
    else $error("alignment check left on");

  a_traps_off: assert property (@(posedge clk_in) disable iff (reset_in) // [RQ14]
    deliver_in |=> !status_q[idv_pkg::PSR_DB] && !status_q[idv_pkg::PSR_LP]
      && !status_q[idv_pkg::PSR_TB] && !status_q[idv_pkg::PSR_SS])
    else $error("debug or trap enable left on");

  a_native_set: assert property (@(posedge clk_in) disable iff (reset_in) // [RQ15]
    deliver_in |=> !status_q[idv_pkg::PSR_IS])
    else $error("instruction set not native");

  a_suppress_off: assert property (@(posedge clk_in) disable iff (reset_in) // [RQ16]
    deliver_in |=> !status_q[idv_pkg::PSR_ID] && !status_q[idv_pkg::PSR_DA]
      && !status_q[idv_pkg::PSR_IA] && !status_q[idv_pkg::PSR_DD]
      && !status_q[idv_pkg::PSR_ED])
    else $error("suppression or deferral left on");

  a_slot_zero: assert property (@(posedge clk_in) disable iff (reset_in) // [RQ17]
    deliver_in |=> status_q[idv_pkg::PSR_RI_HI:idv_pkg::PSR_RI_LO] == 2'h0)
    else $error("restart slot not cleared");

  a_mask_kept: assert property (@(posedge clk_in) disable iff (reset_in) // [RQ18]
    deliver_in |=> status_q[idv_pkg::PSR_MC] == $past(status_q[idv_pkg::PSR_MC]))
    else $error("machine-check mask changed");

  a_abort_unmask: assert property (@(posedge clk_in) disable iff (reset_in) // [RQ18]
    bus_init_in || reset_evt_in |-> abort_out)
    else $error("reset or bus init masked");

  a_mcheck_open: assert property (@(posedge clk_in) disable iff (reset_in) // [RQ18]
    mcheck_req_in && !status_q[idv_pkg::PSR_MC] |-> abort_out)
    else $error("unmasked machine check dropped");

  a_cfle_clear: assert property (@(posedge clk_in) disable iff (reset_in) // [RQ19]
    deliver_in |=> !frame_load_enable_out
      && status_q[idv_pkg::PSR_RI_HI:idv_pkg::PSR_RI_LO] == 2'h0)
    else $error("frame load or slot not cleared");

  a_cause_save: assert property (@(posedge clk_in) disable iff (reset_in) // [RQ20]
    deliver_in && collect |=> isr_q == $past(cause_info_in))
    else $error("cause not recorded");

  a_save_word: assert property (@(posedge clk_in) disable iff (reset_in) // [RQ22]
    deliver_in && collect |=> saved_q[idv_pkg::PSR_RI_HI:idv_pkg::PSR_RI_LO]
      == $past(cur_slot_in) && saved_q[idv_pkg::COLLECTION_ENABLE])
    else $error("saved status wrong");

  a_rfi_back: assert property (@(posedge clk_in) disable iff (reset_in) // [RQ23]
    do_rfi |=> status_q == $past(saved_q) && redirect_out
      && fetch_addr_out == $past(saved_ip_q))
    else $error("return did not restore");

  a_rfi_virt: assert property (@(posedge clk_in) disable iff (reset_in) // [RQ23]
    do_rfi |=> fetch_virtual_out == $past(saved_q[idv_pkg::INSTR_TRANSLATION_ON]))
    else $error("return translation mode wrong");

  a_save_only: assert property (@(posedge clk_in) disable iff (reset_in) // [RQ24]
    deliver_in && !collect |=> $stable(saved_q) && $stable(isr_q))
    else $error("capture with collection off");
endmodule // idv_delivery
`default_nettype wire

// file: verification/test_interruption_delivery_state.sv
`timescale 1ns/1ps
`default_nettype none
module test_interruption_delivery_state;
  // Bits that delivery forces to zero, in the status layout of the package
  localparam logic [63:0] CLR = 64'h00003FE7_07DC6008;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic deliver_in = 1'b0;
  logic rfi_in = 1'b0;
  logic [14:0] vec_offset_in = 15'h0;
  logic [31:0] cur_ip_in = 32'h0;
  logic [31:0] cause_info_in = 32'h0;
  logic [1:0] cur_slot_in = 2'h0;
  logic pmi_req_in = 1'b0;
  logic mcheck_req_in = 1'b0;
  logic bus_init_in = 1'b0;
  logic reset_evt_in = 1'b0;
  logic [31:0] prdata_out, fetch_addr_out;
  logic pready_out, pslverr_out, redirect_out, fetch_virtual_out;
  logic frame_load_enable_out, pmi_deliver_out, abort_out;
  logic [63:0] status_out;
  int miscompares = 0;
  int comparisons = 0;
  integer seed = 47;
  logic [32:0] rd_q[$];
  logic [98:0] dl_q[$];
  logic [63:0] st = 64'h0;
  logic [63:0] sv = 64'h0;
  logic [31:0] sip = 32'h0;
  logic [31:0] interruption_status_reg = 32'h0;
  logic [31:0] vb = 32'h0;
  logic [1:0] default_control_reg = 2'h0;

  always #2.5 clk_in = ~clk_in;

  idv_delivery dut_u (
    .clk_in(clk_in), .reset_in(reset_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .deliver_in(deliver_in), .vec_offset_in(vec_offset_in), .cur_ip_in(cur_ip_in),
    .cur_slot_in(cur_slot_in), .cause_info_in(cause_info_in), .rfi_in(rfi_in),
    .pmi_req_in(pmi_req_in), .mcheck_req_in(mcheck_req_in), .bus_init_in(bus_init_in),
    .reset_evt_in(reset_evt_in), .redirect_out(redirect_out),
    .fetch_addr_out(fetch_addr_out), .fetch_virtual_out(fetch_virtual_out),
    .status_out(status_out), .frame_load_enable_out(frame_load_enable_out),
    .pmi_deliver_out(pmi_deliver_out), .abort_out(abort_out)
  );

  task automatic print_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic cmp_value(string nm, logic [63:0] e, logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // An empty queue yields unknowns, so a surplus result is a mismatch
  task automatic cmp_read();
    logic [32:0] e;
    e = rd_q.size() ? rd_q.pop_front() : 33'bx;
    cmp_value("prdata", {32'h0, e[31:0]}, {32'h0, prdata_out});
    cmp_value("pslverr", {63'h0, e[32]}, {63'h0, pslverr_out});
  endtask

  task automatic cmp_deliver();
    logic [98:0] e;
    e = dl_q.size() ? dl_q.pop_front() : 99'bx;
    cmp_value("status", e[98:35], status_out);
    cmp_value("fetch_addr", {32'h0, e[34:3]}, {32'h0, fetch_addr_out});
    cmp_value("fetch_virtual", {63'h0, e[2]}, {63'h0, fetch_virtual_out});
    if (e[1] === 1'b1) begin
      cmp_value("frame_load", {63'h0, e[0]}, {63'h0, frame_load_enable_out});
    end
  endtask

  always @(posedge clk_in) begin
    if (psel_in && penable_in && !pwrite_in && pready_out === 1'b1) begin
      cmp_read();
    end
    if (redirect_out === 1'b1) begin
      cmp_deliver();
    end
  end

  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    int n;
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      print_verdict();
    end else begin
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(posedge clk_in);
    end
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e, logic er);
    rd_q.push_back({er, e});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic deliver();
    logic [63:0] e;
    logic [14:0] off;
    logic [31:0] ip, cz;
    logic [1:0] sl;
    off = 15'($random(seed));
    ip = $random(seed);
    cz = $random(seed);
    sl = 2'({$random(seed)} % 3);
    e = st & ~CLR;
    e[idv_pkg::PSR_BO] = default_control_reg[idv_pkg::DCR_BO];
    e[idv_pkg::PSR_PM] = default_control_reg[idv_pkg::DCR_PM];
    dl_q.push_back({e, vb[31:15], off, st[idv_pkg::INSTR_TRANSLATION_ON], 2'b10});
    if (st[idv_pkg::COLLECTION_ENABLE]) begin
      sv = st;
      sv[idv_pkg::PSR_RI_HI:idv_pkg::PSR_RI_LO] = sl;
      sip = ip;
      interruption_status_reg = cz;
    end
    deliver_in <= 1'b1;
    vec_offset_in <= off;
    cur_ip_in <= ip;
    cur_slot_in <= sl;
    cause_info_in <= cz;
    @(posedge clk_in);
    deliver_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    st = e;
  endtask

  task automatic rfi();
    dl_q.push_back({sv, sip, sv[idv_pkg::INSTR_TRANSLATION_ON], 2'b00});
    rfi_in <= 1'b1;
    @(posedge clk_in);
    rfi_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    st = sv;
  endtask

  initial begin
    logic [31:0] r;
    repeat (16) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    for (int a = 0; a <= 36; a += 4) begin
      rd(8'(a), 32'h0, 1'b0);
    end
    rd(8'h28, 32'h0, 1'b1);
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      vb = r & 32'hFFFF8000;
      apb(1'b1, idv_pkg::OFS_VBASE, r);
      rd(idv_pkg::OFS_VBASE, vb, 1'b0);
      default_control_reg = 2'($random(seed));
      apb(1'b1, idv_pkg::OFS_DCR, {30'h0, default_control_reg});
      st = {$random(seed), $random(seed)};
      st[idv_pkg::COLLECTION_ENABLE] = i[0];
      apb(1'b1, idv_pkg::OFS_STAT_LO, st[31:0]);
      apb(1'b1, idv_pkg::OFS_STAT_HI, st[63:32]);
      apb(1'b1, idv_pkg::OFS_CORE, 32'h1);
      pmi_req_in <= 1'b1;
      mcheck_req_in <= 1'b1;
      @(posedge clk_in);
      cmp_value("pmi_deliver", {63'h0, st[idv_pkg::COLLECTION_ENABLE]}, {63'h0, pmi_deliver_out});
      cmp_value("abort", {63'h0, ~st[idv_pkg::PSR_MC]}, {63'h0, abort_out});
      bus_init_in <= i[1];
      reset_evt_in <= ~i[1];
      @(posedge clk_in);
      cmp_value("abort", 64'h1, {63'h0, abort_out});
      bus_init_in <= 1'b0;
      reset_evt_in <= 1'b0;
      mcheck_req_in <= 1'b0;
      deliver();
      cmp_value("pmi_deliver", 64'h0, {63'h0, pmi_deliver_out});
      pmi_req_in <= 1'b0;
      rd(idv_pkg::OFS_SAVE_LO, sv[31:0], 1'b0);
      rd(idv_pkg::OFS_SAVE_HI, sv[63:32], 1'b0);
      rd(idv_pkg::OFS_SAVE_IP, sip, 1'b0);
      rd(idv_pkg::OFS_ISR, interruption_status_reg, 1'b0);
      rd(idv_pkg::OFS_CORE, {30'h0, st[idv_pkg::INSTR_TRANSLATION_ON], 1'b0}, 1'b0);
      rd(idv_pkg::OFS_STAT_HI, st[63:32], 1'b0);
      if (i[1]) begin
        rfi();
      end
    end
    for (int n = 0; n < 20 && (rd_q.size() || dl_q.size()); n++) begin
      @(posedge clk_in);
    end
    if (rd_q.size() || dl_q.size()) begin
      miscompares++;
    end
    print_verdict();
  end
endmodule // test_interruption_delivery_state
`default_nettype wire
